// >>> design/asq_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz core clock and an 8-bit AXI4-Lite byte address
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH
// ***********************************************
// clock and timing
// ***********************************************
`define ASQ_CLK_HZ          100000000
`define ASQ_ODR_MAX_PER_US  2500
`define ASQ_ODR_MAX_CYCLES  (`ASQ_ODR_MAX_PER_US * (`ASQ_CLK_HZ / 1000000))
`define ASQ_WAKE_PER_US     166666
`define ASQ_WAKE_CYCLES     (`ASQ_WAKE_PER_US * (`ASQ_CLK_HZ / 1000000))
`define ASQ_EXT_EDGES       128
`define ASQ_ODR_CODE_MAX    3'h5
`define ASQ_SETTLE_TICKS    3'h4
`define ASQ_FULL_SCALE      12'hfff
// ***********************************************
// register map
// ***********************************************
`define ASQ_AW              8
`define ASQ_OFF_CTRL        8'h00
`define ASQ_OFF_STATUS      8'h04
`define ASQ_OFF_INT_STATUS  8'h08
`define ASQ_OFF_INT_MASK    8'h0c
`define ASQ_OFF_SAMPLE      8'h10
`define ASQ_OFF_ACT_THRESH  8'h14
`define ASQ_OFF_ACT_TIME    8'h18
// ctrl fields
`define ASQ_CTRL_MODE_LO    0
`define ASQ_CTRL_ODR_LO     2
`define ASQ_CTRL_RANGE_LO   5
`define ASQ_CTRL_FILTER_BW_SELECT    7
`define ASQ_CTRL_CLK_IN     8
`define ASQ_CTRL_SYNC_IN    9
`define ASQ_CTRL_AUTO_MEAS  10
`define ASQ_CTRL_W          11
`define ASQ_CTRL_RST        11'h000
// mode field codes
`define ASQ_MODE_STBY       2'h0
`define ASQ_MODE_MEAS       2'h1
`define ASQ_MODE_WAKE       2'h2
// interrupt bits
`define ASQ_INT_W           3
`define ASQ_INT_READY       0
`define ASQ_INT_ACT         1
`define ASQ_INT_CLIP        2
`define ASQ_RESP_OKAY       2'h0
`define ASQ_RESP_SLVERR     2'h2
`endif

// >>> design/asq_mode_sequencer.sv
// accelerometer core mode sequencer with AXI4-Lite register slave
// assumes accel_mg comes from logic on clk; both event pins are asynchronous
//
// Chosen here: the AXI4-Lite register port and the address map.
`include "asq_map.svh"
module asq_mode_sequencer #(
   parameter int unsigned ODR_MAX_CYCLES = `ASQ_ODR_MAX_CYCLES,
   parameter int unsigned WAKE_CYCLES    = `ASQ_WAKE_CYCLES,
   parameter int unsigned EXT_EDGES      = `ASQ_EXT_EDGES
) (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic                 ce,
   input  wire logic [`ASQ_AW-1:0]   s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [`ASQ_AW-1:0]   s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic [13:0]          accel_mg,
   input  wire logic                 event_out_a_clock_in_i,
   output logic                      event_out_a_clock_in_o,
   output logic                      event_out_a_clock_in_oe,
   input  wire logic                 event_out_b_sync_in_i,
   output logic                      event_out_b_sync_in_o,
   output logic                      event_out_b_sync_in_oe,
   output logic                      irq,
   output logic                      awake,
   output logic                      adc_enable,
   output logic                      sample_strobe,
   output logic                      filter_bw_half,
   output logic [1:0]                range_sel
);
   // ***********************************************
   // state
   // ***********************************************
   asq_pkg::asq_state_t     state_reg, state_next;
   logic [`ASQ_CTRL_W-1:0]  ctrl_reg, ctrl_next;
   logic [`ASQ_INT_W-1:0]   int_reg, int_next, mask_reg, mask_next, ev, clr;
   logic [11:0]             sample_reg, sample_next, thresh_reg, thresh_next;
   logic [7:0]              atime_reg, atime_next, acnt_reg, acnt_next;
   logic [31:0]             cnt_reg, cnt_next, limit;
   logic [2:0]              settle_reg, settle_next;
   logic                    valid_reg, valid_next, awake_reg, awake_next;
   logic                    sa1, sa2, sa3, sb1, sb2, sb3;
   logic                    aw_rdy_reg, aw_rdy_next, w_rdy_reg, w_rdy_next;
   logic                    ar_rdy_reg, ar_rdy_next, bv_reg, bv_next, rv_reg, rv_next;
   logic [1:0]              bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [`ASQ_AW-1:0]      waddr_reg, waddr_next;
   logic [31:0]             wdata_reg, wdata_next, rdata_reg, rdata_next;
   logic [3:0]              wstrb_reg, wstrb_next;
   logic                    tick, adv, above, act_ev, wr_go, irq_next, strobe_next;
   logic [13:0]             scaled;
   logic                    adc_reg;

   // ***********************************************
   // helpers
   // ***********************************************
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
      return old;
   endfunction

   function automatic logic [1:0] mode_code(input asq_pkg::asq_state_t s);
      case (s)
         asq_pkg::ASQ_MEAS: mode_code = `ASQ_MODE_MEAS;
         asq_pkg::ASQ_WAKE: mode_code = `ASQ_MODE_WAKE;
         default:           mode_code = `ASQ_MODE_STBY;
      endcase
   endfunction

   function automatic logic mapped(input logic [`ASQ_AW-1:0] a);
      return a == `ASQ_OFF_CTRL || a == `ASQ_OFF_STATUS || a == `ASQ_OFF_INT_STATUS ||
             a == `ASQ_OFF_INT_MASK || a == `ASQ_OFF_SAMPLE ||
             a == `ASQ_OFF_ACT_THRESH || a == `ASQ_OFF_ACT_TIME;
   endfunction

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      logic [31:0] m;
      logic [2:0]  odr;
      m            = 32'h0;
      odr          = 3'h0;
      state_next   = state_reg;
      ctrl_next    = ctrl_reg;
      mask_next    = mask_reg;
      sample_next  = sample_reg;
      thresh_next  = thresh_reg;
      atime_next   = atime_reg;
      acnt_next    = acnt_reg;
      settle_next  = settle_reg;
      valid_next   = valid_reg;
      awake_next   = awake_reg;
      cnt_next     = cnt_reg;
      ev           = '0;
      clr          = '0;
      tick         = 1'b0;
      act_ev       = 1'b0;
      scaled       = 14'(accel_mg >> ctrl_reg[`ASQ_CTRL_RANGE_LO +: 2]);
      above        = 1'b0;
      // faster codes above the top rate clamp to it
      odr = (ctrl_reg[`ASQ_CTRL_ODR_LO +: 3] > `ASQ_ODR_CODE_MAX) ? `ASQ_ODR_CODE_MAX
            : ctrl_reg[`ASQ_CTRL_ODR_LO +: 3];
      limit = (ctrl_reg[`ASQ_CTRL_CLK_IN] ? EXT_EDGES : ODR_MAX_CYCLES)
              << (`ASQ_ODR_CODE_MAX - odr);
      if (state_reg == asq_pkg::ASQ_WAKE) begin
         limit = WAKE_CYCLES;
      end
      adv = ctrl_reg[`ASQ_CTRL_CLK_IN] ? (sa2 & ~sa3) : 1'b1;
      if (state_reg == asq_pkg::ASQ_STBY) begin
         cnt_next = 32'h0;
      end else if (ctrl_reg[`ASQ_CTRL_SYNC_IN]) begin
         tick = sb2 & ~sb3;
      end else if (adv) begin
         if (cnt_reg >= limit - 32'h1) begin
            cnt_next = 32'h0;
            tick     = 1'b1;
         end else begin
            cnt_next = cnt_reg + 32'h1;
         end
      end
      if (tick) begin
         sample_next = (scaled > 14'(`ASQ_FULL_SCALE)) ? `ASQ_FULL_SCALE : scaled[11:0];
         ev[`ASQ_INT_CLIP] = scaled > 14'(`ASQ_FULL_SCALE);
         above = sample_next >= thresh_reg;
         acnt_next = above ? ((acnt_reg == 8'hff) ? acnt_reg : acnt_reg + 8'h1) : 8'h0;
         if (state_reg == asq_pkg::ASQ_WAKE) begin
            act_ev = above;
            valid_next = 1'b1;
         end else begin
            act_ev = above && (acnt_next >= atime_reg || atime_reg == 8'h0);
            if (settle_reg < `ASQ_SETTLE_TICKS) begin
               settle_next = settle_reg + 3'h1;
            end
            valid_next = settle_next >= `ASQ_SETTLE_TICKS;
         end
         ev[`ASQ_INT_ACT]   = act_ev;
         ev[`ASQ_INT_READY] = valid_next;
         if (act_ev) begin
            awake_next = 1'b1;
            if (state_reg == asq_pkg::ASQ_WAKE && ctrl_reg[`ASQ_CTRL_AUTO_MEAS]) begin
               state_next  = asq_pkg::ASQ_MEAS;
               settle_next = 3'h0;
               valid_next  = 1'b0;
            end
         end
      end
      // ctrl write overrides an autonomous mode change in the same cycle; a new event beats a flag clear
      wr_go = !aw_rdy_reg && !w_rdy_reg && !bv_reg;
      if (wr_go) begin
         case (waddr_reg)
            `ASQ_OFF_CTRL: begin
               m = merge({21'h0, ctrl_reg}, wdata_reg, wstrb_reg);
               ctrl_next = m[`ASQ_CTRL_W-1:0];
               case (m[`ASQ_CTRL_MODE_LO +: 2])
                  `ASQ_MODE_MEAS: state_next = asq_pkg::ASQ_MEAS;
                  `ASQ_MODE_WAKE: state_next = asq_pkg::ASQ_WAKE;
                  default:        state_next = asq_pkg::ASQ_STBY;
               endcase
               if (state_next != state_reg) begin
                  settle_next = 3'h0;
                  valid_next  = 1'b0;
                  acnt_next   = 8'h0;
                  cnt_next    = 32'h0;
               end
            end
            `ASQ_OFF_INT_STATUS: begin
               m   = merge(32'h0, wdata_reg, wstrb_reg);
               clr = m[`ASQ_INT_W-1:0];
            end
            `ASQ_OFF_INT_MASK: begin
               m = merge({29'h0, mask_reg}, wdata_reg, wstrb_reg);
               mask_next = m[`ASQ_INT_W-1:0];
            end
            `ASQ_OFF_ACT_THRESH: begin
               m = merge({20'h0, thresh_reg}, wdata_reg, wstrb_reg);
               thresh_next = m[11:0];
            end
            `ASQ_OFF_ACT_TIME: begin
               m = merge({24'h0, atime_reg}, wdata_reg, wstrb_reg);
               atime_next = m[7:0];
            end
            default: begin
            end
         endcase
      end
      // events only come from ticks, which never occur in standby
      int_next    = (int_reg & ~clr) | ev;
      irq_next    = |(int_next & mask_next);
      strobe_next = tick;
   end

   // ***********************************************
   // bus handshakes
   // ***********************************************
   always_comb begin
      aw_rdy_next = aw_rdy_reg;
      w_rdy_next  = w_rdy_reg;
      ar_rdy_next = ar_rdy_reg;
      bv_next     = bv_reg;
      rv_next     = rv_reg;
      bresp_next  = bresp_reg;
      rresp_next  = rresp_reg;
      waddr_next  = waddr_reg;
      wdata_next  = wdata_reg;
      wstrb_next  = wstrb_reg;
      rdata_next  = rdata_reg;
      if (aw_rdy_reg && s_axi_awvalid) begin
         aw_rdy_next = 1'b0;
         waddr_next  = s_axi_awaddr;
      end
      if (w_rdy_reg && s_axi_wvalid) begin
         w_rdy_next = 1'b0;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      if (wr_go) begin
         bv_next    = 1'b1;
         bresp_next = mapped(waddr_reg) ? `ASQ_RESP_OKAY : `ASQ_RESP_SLVERR;
      end
      if (bv_reg && s_axi_bready) begin
         bv_next     = 1'b0;
         aw_rdy_next = 1'b1;
         w_rdy_next  = 1'b1;
      end
      if (ar_rdy_reg && s_axi_arvalid) begin
         ar_rdy_next = 1'b0;
         rv_next     = 1'b1;
         rresp_next  = mapped(s_axi_araddr) ? `ASQ_RESP_OKAY : `ASQ_RESP_SLVERR;
         case (s_axi_araddr)
            `ASQ_OFF_CTRL:       rdata_next = {21'h0, ctrl_reg[`ASQ_CTRL_W-1:2],
                                               mode_code(state_reg)};
            `ASQ_OFF_STATUS:     rdata_next = {28'h0, awake_reg, valid_reg,
                                               mode_code(state_reg)};
            `ASQ_OFF_INT_STATUS: rdata_next = {29'h0, int_reg};
            `ASQ_OFF_INT_MASK:   rdata_next = {29'h0, mask_reg};
            `ASQ_OFF_SAMPLE:     rdata_next = {20'h0, sample_reg};
            `ASQ_OFF_ACT_THRESH: rdata_next = {20'h0, thresh_reg};
            `ASQ_OFF_ACT_TIME:   rdata_next = {24'h0, atime_reg};
            default:             rdata_next = 32'h0;
         endcase
      end
      if (rv_reg && s_axi_rready) begin
         rv_next     = 1'b0;
         ar_rdy_next = 1'b1;
      end
   end

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg <= asq_pkg::ASQ_STBY;
         ctrl_reg <= `ASQ_CTRL_RST;
         int_reg <= '0;
         mask_reg <= '0;
         sample_reg <= 12'h0;
         thresh_reg <= 12'h0;
         atime_reg <= 8'h0;
         acnt_reg <= 8'h0;
         cnt_reg <= 32'h0;
         settle_reg <= 3'h0;
         valid_reg <= 1'b0;
         awake_reg <= 1'b0;
         adc_reg <= 1'b0;
         {sa1, sa2, sa3, sb1, sb2, sb3} <= 6'h0;
         {aw_rdy_reg, w_rdy_reg, ar_rdy_reg} <= 3'h7;
         {bv_reg, rv_reg} <= 2'h0;
         {bresp_reg, rresp_reg} <= 4'h0;
         waddr_reg <= '0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         rdata_reg <= 32'h0;
         irq <= 1'b0;
         sample_strobe <= 1'b0;
         event_out_a_clock_in_o <= 1'b0;
         event_out_a_clock_in_oe <= 1'b1;
         event_out_b_sync_in_o <= 1'b0;
         event_out_b_sync_in_oe <= 1'b1;
      end else if (ce) begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         int_reg <= int_next;
         mask_reg <= mask_next;
         sample_reg <= sample_next;
         thresh_reg <= thresh_next;
         atime_reg <= atime_next;
         acnt_reg <= acnt_next;
         cnt_reg <= cnt_next;
         settle_reg <= settle_next;
         valid_reg <= valid_next;
         awake_reg <= awake_next;
         adc_reg <= state_next != asq_pkg::ASQ_STBY;
         {sa1, sa2, sa3} <= {event_out_a_clock_in_i, sa1, sa2};
         {sb1, sb2, sb3} <= {event_out_b_sync_in_i, sb1, sb2};
         {aw_rdy_reg, w_rdy_reg, ar_rdy_reg} <= {aw_rdy_next, w_rdy_next, ar_rdy_next};
         {bv_reg, rv_reg} <= {bv_next, rv_next};
         {bresp_reg, rresp_reg} <= {bresp_next, rresp_next};
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         rdata_reg <= rdata_next;
         irq <= irq_next;
         sample_strobe <= strobe_next;
         event_out_a_clock_in_o <= irq_next;
         event_out_a_clock_in_oe <= !ctrl_next[`ASQ_CTRL_CLK_IN];
         event_out_b_sync_in_o <= awake_next;
         event_out_b_sync_in_oe <= !ctrl_next[`ASQ_CTRL_SYNC_IN];
      end
   end

   assign s_axi_awready  = aw_rdy_reg;
   assign s_axi_wready   = w_rdy_reg;
   assign s_axi_arready  = ar_rdy_reg;
   assign s_axi_bvalid   = bv_reg;
   assign s_axi_rvalid   = rv_reg;
   assign s_axi_bresp    = bresp_reg;
   assign s_axi_rresp    = rresp_reg;
   assign s_axi_rdata    = rdata_reg;
   assign awake          = awake_reg;
   assign adc_enable     = adc_reg;
   assign filter_bw_half = ctrl_reg[`ASQ_CTRL_FILTER_BW_SELECT];
   assign range_sel      = ctrl_reg[`ASQ_CTRL_RANGE_LO +: 2];

   // ***********************************************
   // checks
   // ***********************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || !ce);

   property p_stby_quiet;
      state_reg == asq_pkg::ASQ_STBY |-> !tick && !adc_enable;
   endproperty
   a_stby_quiet: assert property (p_stby_quiet) else $error("tick in standby");

   property p_stby_no_new;
      state_reg == asq_pkg::ASQ_STBY |=> (int_reg & ~$past(int_reg)) == '0;
   endproperty
   a_stby_no_new: assert property (p_stby_no_new) else $error("new flag in standby");

   property p_reset_stby;
      $rose(resetn) |-> state_reg == asq_pkg::ASQ_STBY && !filter_bw_half;
   endproperty
   a_reset_stby: assert property (@(posedge clk) p_reset_stby) else $error("reset state");

   property p_clip;
      tick && scaled > 14'(`ASQ_FULL_SCALE) |=> sample_reg == `ASQ_FULL_SCALE && int_reg[2];
   endproperty
   a_clip: assert property (p_clip) else $error("no saturation");

   property p_settle;
      $rose(state_reg == asq_pkg::ASQ_MEAS) |-> !valid_reg;
   endproperty
   a_settle: assert property (p_settle) else $error("valid too early");

   property p_wake_single;
      state_reg == asq_pkg::ASQ_WAKE && tick && above |=> int_reg[`ASQ_INT_ACT] && awake_reg;
   endproperty
   a_wake_single: assert property (p_wake_single) else $error("wake activity missed");

   property p_auto_meas;
      state_reg == asq_pkg::ASQ_WAKE && act_ev && ctrl_reg[`ASQ_CTRL_AUTO_MEAS] && !wr_go
      |=> state_reg == asq_pkg::ASQ_MEAS;
   endproperty
   a_auto_meas: assert property (p_auto_meas) else $error("no switch to measure");

   property p_sync;
      state_reg != asq_pkg::ASQ_STBY && ctrl_reg[`ASQ_CTRL_SYNC_IN] && sb2 && !sb3
      |=> sample_strobe;
   endproperty
   a_sync: assert property (p_sync) else $error("sync edge missed");

   property p_irq;
      ##1 irq == |(int_reg & mask_reg);
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   property p_bresp;
      wr_go |=> s_axi_bvalid [*1] ##0 !s_axi_awready;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write not answered");
endmodule

// >>> design/asq_pkg.sv
// types shared by the mode sequencer
// assumes nothing beyond the map header
package asq_pkg;
   typedef enum logic [1:0] {ASQ_STBY, ASQ_MEAS, ASQ_WAKE} asq_state_t;
endpackage

// >>> test/accel_mode_sequencer_test.sv
// register-bus bench for the mode sequencer
// assumes the map header on the include path and the pin partner
`include "asq_map.svh"
module accel_mode_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk = 1'b0;
   logic               resetn, ce, irq, awake, adc_enable, sample_strobe, filter_bw_half;
   logic [`ASQ_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]        s_axi_wdata, s_axi_rdata, rd_d;
   logic [3:0]         s_axi_wstrb;
   logic [1:0]         s_axi_bresp, s_axi_rresp, range_sel, rsp;
   logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic               s_axi_rvalid, s_axi_rready, clk_run, sync_run;
   logic [13:0]        accel_mg;
   logic               event_out_a_clock_in_i, event_out_a_clock_in_o, event_out_a_clock_in_oe;
   logic               event_out_b_sync_in_i, event_out_b_sync_in_o, event_out_b_sync_in_oe;
   int                 mismatches, checks, strobes, base;
   // short counts keep the run brief
   asq_mode_sequencer #(.ODR_MAX_CYCLES(20), .WAKE_CYCLES(50), .EXT_EDGES(2)) i_dut (
      .clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .accel_mg, .event_out_a_clock_in_i,
      .event_out_a_clock_in_o, .event_out_a_clock_in_oe, .event_out_b_sync_in_i,
      .event_out_b_sync_in_o, .event_out_b_sync_in_oe, .irq, .awake, .adc_enable,
      .sample_strobe, .filter_bw_half, .range_sel);
   asq_pin_partner i_far (.clk_run(clk_run), .sync_run(sync_run),
      .a_o(event_out_a_clock_in_o), .a_oe(event_out_a_clock_in_oe),
      .b_o(event_out_b_sync_in_o), .b_oe(event_out_b_sync_in_oe),
      .a_level(event_out_a_clock_in_i), .b_level(event_out_b_sync_in_i));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (sample_strobe === 1'b1)
         strobes <= strobes + 1;
   end
   // ********
   // bus tasks and compares
   // ********
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // channels may be taken on different edges
      do begin
         @(posedge clk);
         if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid === 1'b1 || s_axi_wvalid === 1'b1);
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      rd_d = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task automatic cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cmp_p(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      rd(a);
      cmp_w(nm, e, rd_d & m);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(40000);
      mismatches++;
      stop_test();
   end
   // ********
   // scenarios
   // ********
   initial begin
      // response readies stay high so back-to-back calls never toggle them in one step
      {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h05;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {clk_run, sync_run, ce, s_axi_wstrb, accel_mg} = {3'h1, 4'hf, 14'h0000};
      {mismatches, checks, strobes, base} = 0;
      cyc(3);
      resetn <= 1'b1;
      cyc(1);
      cmp_p("adc_enable", 1'b0, adc_enable);
      cmp_p("filter_bw_half", 1'b0, filter_bw_half);
      cmp_p("oe_a", 1'b1, event_out_a_clock_in_oe);
      cmp_p("oe_b", 1'b1, event_out_b_sync_in_oe);
      rd_chk("ctrl", `ASQ_OFF_CTRL, 32'hffffffff, 32'h0);
      rd_chk("status", `ASQ_OFF_STATUS, 32'hffffffff, 32'h0);
      wr(8'h1c, 32'h1);
      cmp_w("bresp", 32'h2, {30'h0, rsp});
      rd_chk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
      cmp_w("rresp", 32'h2, {30'h0, rsp});
      wr(`ASQ_OFF_INT_MASK, 32'h7);
      rd_chk("mask", `ASQ_OFF_INT_MASK, 32'hffffffff, 32'h7);
      wr(`ASQ_OFF_ACT_THRESH, 32'hfff);
      accel_mg <= 14'd100;
      wr(`ASQ_OFF_CTRL, 32'h95);
      cmp_p("adc_enable", 1'b1, adc_enable);
      cmp_p("filter_bw_half", 1'b1, filter_bw_half);
      cyc(40);
      rd_chk("status", `ASQ_OFF_STATUS, 32'hf, 32'h1);
      cyc(60);
      rd_chk("status", `ASQ_OFF_STATUS, 32'hf, 32'h5);
      rd_chk("sample", `ASQ_OFF_SAMPLE, 32'hffffffff, 32'h64);
      cmp_p("irq", 1'b1, irq);
      // codes 6 and 7 run at the top rate
      for (int c = 0; c < 8; c++) begin
         wr(`ASQ_OFF_CTRL, 32'h81 | (c << 2));
         cyc(700);
         base = strobes;
         cyc(1280);
         cmp_w("odr ticks", 1280 / (20 << (5 - ((c > 5) ? 5 : c))), strobes - base);
      end
      for (int r = 0; r < 3; r++) begin
         wr(`ASQ_OFF_CTRL, 32'h95 | (r << 5));
         cyc(30);
         rd_chk("sample", `ASQ_OFF_SAMPLE, 32'hffffffff, 100 >> r);
         cmp_w("range_sel", r, {30'h0, range_sel});
      end
      wr(`ASQ_OFF_CTRL, 32'h95);
      accel_mg <= 14'h3fff;
      cyc(30);
      rd_chk("sample", `ASQ_OFF_SAMPLE, 32'hffffffff, 32'hfff);
      rd_chk("int_status", `ASQ_OFF_INT_STATUS, 32'hffffffff, 32'h7);
      cmp_p("pin_a", 1'b1, event_out_a_clock_in_o);
      // unused mode code 3 falls back to standby
      wr(`ASQ_OFF_CTRL, 32'h3);
      cmp_p("adc_enable", 1'b0, adc_enable);
      rd_chk("ctrl", `ASQ_OFF_CTRL, 32'h3, 32'h0);
      cyc(20);
      rd_chk("int_status", `ASQ_OFF_INT_STATUS, 32'hffffffff, 32'h7);
      wr(`ASQ_OFF_INT_STATUS, 32'h7);
      base = strobes;
      cyc(100);
      rd_chk("int_status", `ASQ_OFF_INT_STATUS, 32'hffffffff, 32'h0);
      cmp_w("stby ticks", 32'h0, strobes - base);
      cmp_p("irq", 1'b0, irq);
      // second reset mid-run clears the awake latch
      resetn <= 1'b0;
      cyc(3);
      resetn <= 1'b1;
      cyc(1);
      cmp_p("awake", 1'b0, awake);
      cmp_p("adc_enable", 1'b0, adc_enable);
      wr(`ASQ_OFF_ACT_THRESH, 32'hfff);
      accel_mg <= 14'h0000;
      wr(`ASQ_OFF_CTRL, 32'h2);
      cmp_p("adc_enable", 1'b1, adc_enable);
      cyc(60);
      base = strobes;
      cyc(500);
      cmp_w("wake ticks", 32'd10, strobes - base);
      rd_chk("sample", `ASQ_OFF_SAMPLE, 32'hffffffff, 32'h0);
      wr(`ASQ_OFF_ACT_TIME, 32'h5);
      accel_mg <= 14'h3fff;
      wr(`ASQ_OFF_CTRL, 32'h402);
      cyc(80);
      cmp_p("awake", 1'b1, awake);
      cmp_p("pin_b", 1'b1, event_out_b_sync_in_o);
      rd_chk("status", `ASQ_OFF_STATUS, 32'hb, 32'h9);
      rd_chk("int_status", `ASQ_OFF_INT_STATUS, 32'h2, 32'h2);
      wr(`ASQ_OFF_CTRL, 32'h115);
      cmp_p("oe_a", 1'b0, event_out_a_clock_in_oe);
      cmp_p("filter_bw_half", 1'b0, filter_bw_half);
      cyc(20);
      base = strobes;
      cyc(100);
      cmp_w("still ticks", 32'h0, strobes - base);
      clk_run <= 1'b1;
      cyc(40);
      base = strobes;
      cyc(1000);
      cmp_p("ext ticks", 1'b1, strobes - base >= 39 && strobes - base <= 41);
      clk_run <= 1'b0;
      wr(`ASQ_OFF_CTRL, 32'h201);
      cmp_p("oe_b", 1'b0, event_out_b_sync_in_oe);
      sync_run <= 1'b1;
      cyc(30);
      base = strobes;
      cyc(1000);
      cmp_p("sync ticks", 1'b1, strobes - base >= 19 && strobes - base <= 21);
      sync_run <= 1'b0;
      stop_test();
   end
endmodule

// >>> test/asq_pin_partner.sv
// far-side pin source: external sample clock and sync trigger
// assumes the bench enables a source only after the pin is an input
// ********
// pin partner
// ********
module asq_pin_partner (
   input  wire logic clk_run,
   input  wire logic sync_run,
   input  wire logic a_o,
   input  wire logic a_oe,
   input  wire logic b_o,
   input  wire logic b_oe,
   output logic      a_level,
   output logic      b_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ext_clk = 1'b0;
   logic sync_lvl = 1'b0;
   // stands still between bursts, phase free of the core clock
   always begin
      #62.5;
      ext_clk = clk_run ? ~ext_clk : 1'b0;
   end
   always begin
      #250;
      sync_lvl = sync_run ? ~sync_lvl : 1'b0;
   end
   // device owns the wire while it drives
   assign a_level = a_oe ? a_o : ext_clk;
   assign b_level = b_oe ? b_o : sync_lvl;
endmodule
